// ### rtl/icd_defines.svh
`ifndef ICD_DEFINES_SVH
`define ICD_DEFINES_SVH

// Channel count and data widths
`define ICD_NCH            4
`define ICD_VAL_W          24
`define ICD_OFS_W          16
`define ICD_CNT_W          16
`define ICD_FLAG_W         16
`define ICD_ADDR_W         8

// Word indices of the register map (byte address = index * 4)
`define ICD_IDX_CFG0       6'h00
`define ICD_IDX_OFS0       6'h04
`define ICD_IDX_CTRL       6'h08
`define ICD_IDX_FLAGS      6'h09
`define ICD_IDX_IRQ_STAT   6'h0a
`define ICD_IDX_IRQ_MASK   6'h0b
`define ICD_IDX_DIAG_CNT   6'h0c

// Channel configuration and control word fields
`define ICD_CFG_MODE_LSB   0
`define ICD_CFG_SENS_LSB   2
`define ICD_CFG_UNIT_LSB   6
`define ICD_CFG_WBEN_BIT   9
`define ICD_CFG_CJDIS_BIT  10
`define ICD_CFG_RANGE_BIT  11
`define ICD_CTRL_NOALM_BIT 0

// Sensor selection codes
`define ICD_SENS_CU10      4'h8
`define ICD_SENS_TC_MV     4'hf

// Per-channel flag layout (bit = channel * 4 + field)
`define ICD_FL_WB          0
`define ICD_FL_FAULT       1
`define ICD_FL_CJBAD       2
`define ICD_FL_OVHT        3

// Thresholds: current in nA, voltage in mV
`define ICD_CUR_MIN_NA     24'h01_86a0
`define ICD_VFS_WIDE_MV    24'h00_2710
`define ICD_VFS_NARROW_MV  24'h00_1388

// Reset values and the counter value after wrap
`define ICD_CFG_RST        32'h0000_0000
`define ICD_OFS_RST        16'h0000
`define ICD_CNT_WRAP       16'h0001

`endif

// ### rtl/icd_pkg.sv
`default_nettype none
`include "icd_defines.svh"

package icd_pkg;

    // Input mode of a channel
    typedef enum logic [1:0] {
        ICD_MODE_CURRENT = 2'h0,
        ICD_MODE_VOLTAGE = 2'h1,
        ICD_MODE_RTD     = 2'h2,
        ICD_MODE_TC      = 2'h3
    } icd_mode_t;

    // Temperature unit per channel
    typedef enum logic [2:0] {
        ICD_UNIT_C      = 3'h0,
        ICD_UNIT_K      = 3'h1,
        ICD_UNIT_F      = 3'h2,
        ICD_UNIT_R      = 3'h3,
        ICD_UNIT_CUSTOM = 3'h4
    } icd_unit_t;

    // One converted sample from the front end
    typedef struct packed {
        logic                          valid;
        logic signed [`ICD_VAL_W-1:0]  value;
        logic                          wire_open;
        logic                          quality_bad;
        logic                          cj_quality_bad;
        logic signed [`ICD_VAL_W-1:0]  cj_value;
    } icd_sample_t;

    // One reported channel record
    typedef struct packed {
        logic                          valid;
        logic signed [`ICD_VAL_W-1:0]  value;
        logic                          wire_break_flag;
        logic                          fault;
        logic                          cold_junction_bad_flag;
        logic                          overheat_flag;
        icd_unit_t                     unit;
    } icd_report_t;

endpackage
`default_nettype wire

// ### rtl/icd_input_channel_diagnostics.sv
// Behaviour
// [R1] Copper offset applied only for RTD channels with ten-ohm copper sensor selected.
// [R2] Copper offset is signed, in hundredths of an ohm.
// [R3] Wire-break detection runs only when the channel enable bit is set.
// [R4] Current below 100 uA sets wire-break and fault flags.
// [R5] Voltage at range full scale sets wire-break and fault flags.
// [R6] RTD or thermocouple open wire sets wire-break and fault flags.
// [R7] Global alarm disable never suppresses wire-break detection.
// [R8] Wire break is an indicator and fault only, never an alarm bit.
// [R9] Each channel holds its own temperature unit selection.
// [R10] Over-temperature condition sets every channel's overheat flag.
// [R11] Thermocouple channels are corrected by the cold junction value; the code skips this for sensor code ICD_SENS_TC_MV.
// [R12] Cold junction correction can be switched off per channel.
// [R13] Flags travel together with channel data in every report.
// [R14] Controller side flags connection loss; not this block.
// [R15] Bad channel data quality sets the channel fault flag.
// [R16] Bad cold junction quality sets the separate cold junction flag.
// [R17] Change counter increments on any flag change, skipping zero on wrap.
// [R18] Signed copper offset is added to measured resistance before reporting.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
`include "icd_defines.svh"

module icd_input_channel_diagnostics (
    input  wire logic                               clk_i,
    input  wire logic                               srst_i,
    input  wire logic [`ICD_ADDR_W-1:0]             avs_address_i,
    input  wire logic                               avs_read_i,
    input  wire logic                               avs_write_i,
    input  wire logic [31:0]                        avs_writedata_i,
    input  wire logic [3:0]                         avs_byteenable_i,
    output logic      [31:0]                        avs_readdata_o,
    output logic                                    avs_waitrequest_o,
    input  wire icd_pkg::icd_sample_t [`ICD_NCH-1:0] sample_i,
    input  wire logic                               overheat_sense_i,
    output var  icd_pkg::icd_report_t [`ICD_NCH-1:0] report_o,
    output logic      [`ICD_CNT_W-1:0]              diag_change_counter_o,
    output logic                                    irq_o
);
    import icd_pkg::*;

    // Saturating signed add of two sample-width values
    function automatic logic signed [`ICD_VAL_W-1:0] icd_add(
        input logic signed [`ICD_VAL_W-1:0] a,
        input logic signed [`ICD_VAL_W-1:0] b
    );
        logic signed [`ICD_VAL_W:0] s;
        s = {a[`ICD_VAL_W-1], a} + {b[`ICD_VAL_W-1], b};
        if (s[`ICD_VAL_W] != s[`ICD_VAL_W-1]) begin
            icd_add = s[`ICD_VAL_W] ? {1'b1, {(`ICD_VAL_W-1){1'b0}}} : {1'b0, {(`ICD_VAL_W-1){1'b1}}};
        end else begin
            icd_add = s[`ICD_VAL_W-1:0];
        end
    endfunction

    // Merge write data into a register under byte enables
    function automatic logic [31:0] icd_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  be
    );
        for (int b = 0; b < 4; b++) begin
            old_v[b*8 +: 8] = be[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
        end
        icd_merge = old_v;
    endfunction

    // Register file and bus state
    logic [31:0]             cfg [`ICD_NCH];
    logic [31:0]             next_cfg [`ICD_NCH];
    logic [`ICD_OFS_W-1:0]   ofs [`ICD_NCH];
    logic [`ICD_OFS_W-1:0]   next_ofs [`ICD_NCH];
    logic                    no_alarms;
    logic                    next_no_alarms;
    logic [`ICD_FLAG_W-1:0]  irq_stat;
    logic [`ICD_FLAG_W-1:0]  next_irq_stat;
    logic [`ICD_FLAG_W-1:0]  irq_mask;
    logic [`ICD_FLAG_W-1:0]  next_irq_mask;
    logic                    ack;
    logic                    next_ack;
    logic [31:0]             rdata;
    logic [31:0]             next_rdata;

    // Diagnostic state
    logic [`ICD_FLAG_W-1:0]  flags;
    logic [`ICD_FLAG_W-1:0]  next_flags;
    icd_report_t [`ICD_NCH-1:0] rep;
    icd_report_t [`ICD_NCH-1:0] next_rep;
    logic [`ICD_CNT_W-1:0]   cnt;
    logic [`ICD_CNT_W-1:0]   next_cnt;
    logic                    ot_meta;
    logic                    ot_sync;

    logic [5:0]              idx;
    logic                    wr_acc;
    logic                    rd_acc;
    logic [`ICD_FLAG_W-1:0]  events;

    assign idx    = avs_address_i[`ICD_ADDR_W-1:2];
    assign wr_acc = avs_write_i & ack;
    assign rd_acc = avs_read_i & ack;

    // One wait state on every access; request accepted when ack is high
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
    assign avs_readdata_o    = rdata;
    assign irq_o             = |(irq_stat & irq_mask);
    assign report_o          = rep;
    assign diag_change_counter_o = cnt;
    assign events            = next_flags & ~flags;

    // Register file next state and read mux
    always_comb begin
        next_ack       = (avs_read_i | avs_write_i) & ~ack;
        next_no_alarms = no_alarms;
        next_irq_mask  = irq_mask;
        next_rdata     = rdata;
        for (int c = 0; c < `ICD_NCH; c++) begin
            next_cfg[c] = cfg[c];
            next_ofs[c] = ofs[c];
        end
        // Unmapped addresses read zero and ignore writes
        if (avs_read_i && !ack) begin
            next_rdata = 32'h0000_0000;
            if (idx < `ICD_IDX_OFS0) begin
                next_rdata = cfg[idx[1:0]];
            end else if (idx < `ICD_IDX_CTRL) begin
                next_rdata = {{(32-`ICD_OFS_W){ofs[idx[1:0]][`ICD_OFS_W-1]}}, ofs[idx[1:0]]};
            end else begin
                case (idx)
                    `ICD_IDX_CTRL:     next_rdata[`ICD_CTRL_NOALM_BIT] = no_alarms;
                    `ICD_IDX_FLAGS:    next_rdata[`ICD_FLAG_W-1:0] = flags;
                    `ICD_IDX_IRQ_STAT: next_rdata[`ICD_FLAG_W-1:0] = irq_stat;
                    `ICD_IDX_IRQ_MASK: next_rdata[`ICD_FLAG_W-1:0] = irq_mask;
                    `ICD_IDX_DIAG_CNT: next_rdata[`ICD_CNT_W-1:0] = cnt;
                    default:           next_rdata = 32'h0000_0000;
                endcase
            end
        end
        if (wr_acc) begin
            if (idx < `ICD_IDX_OFS0) begin
                next_cfg[idx[1:0]] = icd_merge(cfg[idx[1:0]], avs_writedata_i, avs_byteenable_i);
            end else if (idx < `ICD_IDX_CTRL) begin
                next_ofs[idx[1:0]] = `ICD_OFS_W'(icd_merge({16'h0000, ofs[idx[1:0]]}, avs_writedata_i,
                                                           avs_byteenable_i)); // [R2]
            end else if (idx == `ICD_IDX_CTRL && avs_byteenable_i[0]) begin
                next_no_alarms = avs_writedata_i[`ICD_CTRL_NOALM_BIT]; // [R7]
            end else if (idx == `ICD_IDX_IRQ_MASK) begin
                next_irq_mask = `ICD_FLAG_W'(icd_merge({16'h0000, irq_mask}, avs_writedata_i,
                                                      avs_byteenable_i));
            end
        end
        // Read clears only the bits returned; new events win over the clear
        next_irq_stat = irq_stat;
        if (rd_acc && idx == `ICD_IDX_IRQ_STAT) begin
            next_irq_stat = irq_stat & ~rdata[`ICD_FLAG_W-1:0];
        end
        next_irq_stat = next_irq_stat | events;
    end

    // Register file storage
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            for (int c = 0; c < `ICD_NCH; c++) begin
                cfg[c] <= `ICD_CFG_RST;
                ofs[c] <= `ICD_OFS_RST;
            end
            no_alarms <= 1'b0;
            irq_stat  <= '0;
            irq_mask  <= '0;
            ack       <= 1'b0;
            rdata     <= 32'h0000_0000;
        end else begin
            for (int c = 0; c < `ICD_NCH; c++) begin
                cfg[c] <= next_cfg[c];
                ofs[c] <= next_ofs[c];
            end
            no_alarms <= next_no_alarms;
            irq_stat  <= next_irq_stat;
            irq_mask  <= next_irq_mask;
            ack       <= next_ack;
            rdata     <= next_rdata;
        end
    end

    // Per-channel correction, wire-break and fault evaluation
    always_comb begin
        icd_mode_t                   mode;
        logic [3:0]                  sens;
        logic                        wb;
        logic                        cjb;
        logic signed [`ICD_VAL_W-1:0] v;
        logic signed [`ICD_VAL_W-1:0] vfs;
        mode = ICD_MODE_CURRENT;
        sens = 4'h0;
        wb   = 1'b0;
        cjb  = 1'b0;
        v    = '0;
        vfs  = '0;
        next_flags = flags;
        next_rep   = rep;
        for (int c = 0; c < `ICD_NCH; c++) begin
            mode = icd_mode_t'(cfg[c][`ICD_CFG_MODE_LSB +: 2]);
            sens = cfg[c][`ICD_CFG_SENS_LSB +: 4];
            vfs  = cfg[c][`ICD_CFG_RANGE_BIT] ? `ICD_VFS_NARROW_MV : `ICD_VFS_WIDE_MV;
            v    = sample_i[c].value;
            wb   = 1'b0;
            cjb  = 1'b0;
            case (mode)
                ICD_MODE_CURRENT: wb = (v < $signed(`ICD_CUR_MIN_NA)); // [R4]
                ICD_MODE_VOLTAGE: wb = (v >= vfs); // [R5]
                ICD_MODE_RTD: begin
                    wb = sample_i[c].wire_open; // [R6]
                    if (sens == `ICD_SENS_CU10) begin
                        v = icd_add(v, `ICD_VAL_W'(signed'(ofs[c]))); // [R1] [R18]
                    end
                end
                ICD_MODE_TC: begin
                    wb  = sample_i[c].wire_open; // [R6]
                    cjb = sample_i[c].cj_quality_bad; // [R16]
                    if (!cfg[c][`ICD_CFG_CJDIS_BIT] && sens != `ICD_SENS_TC_MV) begin
                        v = icd_add(v, sample_i[c].cj_value); // [R11] [R12]
                    end
                end
                default: wb = 1'b0;
            endcase
            // Alarm disable is deliberately not consulted here
            wb = wb & cfg[c][`ICD_CFG_WBEN_BIT]; // [R3] [R7] [R8]
            next_rep[c].valid = sample_i[c].valid;
            if (sample_i[c].valid) begin
                next_flags[c*4 + `ICD_FL_WB]    = wb;
                next_flags[c*4 + `ICD_FL_FAULT] = wb | sample_i[c].quality_bad; // [R4] [R15]
                next_flags[c*4 + `ICD_FL_CJBAD] = cjb; // [R16]
                next_rep[c].value = v;
                next_rep[c].unit  = icd_unit_t'(cfg[c][`ICD_CFG_UNIT_LSB +: 3]); // [R9]
            end
            next_flags[c*4 + `ICD_FL_OVHT] = ot_sync; // [R10]
            next_rep[c].wire_break_flag        = next_flags[c*4 + `ICD_FL_WB]; // [R13]
            next_rep[c].fault                  = next_flags[c*4 + `ICD_FL_FAULT];
            next_rep[c].cold_junction_bad_flag = next_flags[c*4 + `ICD_FL_CJBAD];
            next_rep[c].overheat_flag          = next_flags[c*4 + `ICD_FL_OVHT];
        end
        // Change counter skips zero on wrap
        next_cnt = cnt;
        if (next_flags != flags) begin
            next_cnt = (cnt == {`ICD_CNT_W{1'b1}}) ? `ICD_CNT_WRAP : cnt + `ICD_CNT_WRAP; // [R17]
        end
    end

    // Diagnostic storage and over-temperature synchroniser
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            flags   <= '0;
            rep     <= '0;
            cnt     <= '0;
            ot_meta <= 1'b0;
            ot_sync <= 1'b0;
        end else begin
            flags   <= next_flags;
            rep     <= next_rep;
            cnt     <= next_cnt;
            ot_meta <= overheat_sense_i;
            ot_sync <= ot_meta;
        end
    end

    // Checks on channel 0 and the counter
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    logic s0v;
    logic [3:0] s0sens;
    logic [1:0] s0mode;
    logic s0wben;
    assign s0v    = sample_i[0].valid;
    assign s0sens = cfg[0][`ICD_CFG_SENS_LSB +: 4];
    assign s0mode = cfg[0][`ICD_CFG_MODE_LSB +: 2];
    assign s0wben = cfg[0][`ICD_CFG_WBEN_BIT];

    property p_copper;
        s0v && s0mode == ICD_MODE_RTD && s0sens == `ICD_SENS_CU10
            |=> rep[0].value == icd_add($past(sample_i[0].value), `ICD_VAL_W'(signed'($past(ofs[0]))));
    endproperty
    a_copper: assert property (p_copper) else $error("copper offset not added"); // [R1] [R18]

    property p_no_copper;
        s0v && s0mode == ICD_MODE_RTD && s0sens != `ICD_SENS_CU10 |=> rep[0].value == $past(sample_i[0].value);
    endproperty
    a_no_copper: assert property (p_no_copper) else $error("offset applied to non-copper sensor"); // [R1]

    property p_wb_gate;
        s0v && !s0wben |=> !rep[0].wire_break_flag && !flags[`ICD_FL_WB];
    endproperty
    a_wb_gate: assert property (p_wb_gate) else $error("wire break while detection disabled"); // [R3]

    property p_current;
        s0v && s0wben && s0mode == ICD_MODE_CURRENT && sample_i[0].value < $signed(`ICD_CUR_MIN_NA)
            |=> rep[0].wire_break_flag && rep[0].fault;
    endproperty
    a_current: assert property (p_current) else $error("low current not flagged"); // [R4] [R7]

    property p_voltage;
        s0v && s0wben && s0mode == ICD_MODE_VOLTAGE && !cfg[0][`ICD_CFG_RANGE_BIT]
            && sample_i[0].value >= $signed(`ICD_VFS_WIDE_MV) |=> rep[0].wire_break_flag && rep[0].fault;
    endproperty
    a_voltage: assert property (p_voltage) else $error("full scale voltage not flagged"); // [R5]

    property p_open;
        s0v && s0wben && s0mode[1] && sample_i[0].wire_open |=> rep[0].wire_break_flag ##0 rep[0].fault;
    endproperty
    a_open: assert property (p_open) else $error("open wire not flagged"); // [R6]

    property p_overheat;
        $rose(overheat_sense_i) ##1 overheat_sense_i |=> ##1 rep[0].overheat_flag && rep[3].overheat_flag;
    endproperty
    a_overheat: assert property (p_overheat) else $error("overheat not reported"); // [R10]

    property p_cjc_off;
        s0v && s0mode == ICD_MODE_TC && cfg[0][`ICD_CFG_CJDIS_BIT] |=> rep[0].value == $past(sample_i[0].value);
    endproperty
    a_cjc_off: assert property (p_cjc_off) else $error("cold junction applied while disabled"); // [R12]

    property p_cjc_on;
        s0v && s0mode == ICD_MODE_TC && !cfg[0][`ICD_CFG_CJDIS_BIT] && s0sens != `ICD_SENS_TC_MV
            |=> rep[0].value == icd_add($past(sample_i[0].value), $past(sample_i[0].cj_value));
    endproperty
    a_cjc_on: assert property (p_cjc_on) else $error("cold junction not applied"); // [R11]

    property p_quality;
        s0v && sample_i[0].quality_bad |=> rep[0].fault && rep[0].valid;
    endproperty
    a_quality: assert property (p_quality) else $error("bad quality not faulted"); // [R15] [R13]

    property p_cj_bad;
        s0v && s0mode == ICD_MODE_TC && sample_i[0].cj_quality_bad |=> rep[0].cold_junction_bad_flag;
    endproperty
    a_cj_bad: assert property (p_cj_bad) else $error("cold junction quality not flagged"); // [R16]

    property p_counter;
        flags != $past(flags) |-> cnt != '0 && cnt != $past(cnt);
    endproperty
    a_counter: assert property (p_counter) else $error("change counter wrong"); // [R17]

    // Bus answer, per-channel unit, report pairing, counter wrap, set over clear
    property p_wait;
        (avs_read_i || avs_write_i) && !ack |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
    endproperty
    a_wait: assert property (p_wait) else $error("wait state count wrong");

    property p_unit;
        s0v |=> rep[0].unit == $past(cfg[0][`ICD_CFG_UNIT_LSB +: 3]);
    endproperty
    a_unit: assert property (p_unit) else $error("unit not taken per channel"); // [R9]

    property p_pair;
        s0v |=> rep[0].valid && rep[0].fault == flags[`ICD_FL_FAULT];
    endproperty
    a_pair: assert property (p_pair) else $error("report and flags apart"); // [R13]

    property p_wrap;
        cnt == {`ICD_CNT_W{1'b1}} && next_flags != flags |=> cnt == `ICD_CNT_WRAP;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not skip zero"); // [R17]

    property p_irq_set;
        events[`ICD_FL_WB] |=> irq_stat[`ICD_FL_WB];
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("event lost against clear");

    c_wire_break: cover property (s0v && s0wben ##1 rep[0].wire_break_flag);
    c_copper:     cover property (s0v && s0mode == ICD_MODE_RTD && s0sens == `ICD_SENS_CU10);
    c_irq:        cover property (irq_o ##[1:20] !irq_o);
    c_wrap:       cover property (cnt == {`ICD_CNT_W{1'b1}} ##1 cnt == `ICD_CNT_WRAP);

endmodule
`default_nettype wire

// ### test/icd_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "icd_defines.svh"

module icd_ctrl_model (
    input  wire logic                                clk_i,
    input  wire logic                                srst_i,
    input  wire icd_pkg::icd_report_t [`ICD_NCH-1:0] report_i,
    output var  icd_pkg::icd_report_t [`ICD_NCH-1:0] last_o,
    output logic                                     owner_link_lost_o
);
    import icd_pkg::*;
    logic [7:0] quiet;
    logic       any_v;

    // Any channel delivered a record this cycle
    always_comb begin
        any_v = 1'b0;
        for (int c = 0; c < `ICD_NCH; c++) begin
            any_v = any_v | report_i[c].valid;
        end
    end

    // Keep newest record per channel; data and flags stay paired
    always_ff @(posedge clk_i) begin
        for (int c = 0; c < `ICD_NCH; c++) begin
            if (srst_i) begin
                last_o[c] <= '0;
            end else if (report_i[c].valid) begin
                last_o[c] <= report_i[c];
            end
        end
    end

    // Long silence from the module means the link is gone
    always_ff @(posedge clk_i) begin
        if (srst_i || any_v) begin
            quiet <= 8'h00;
        end else if (quiet != 8'hff) begin
            quiet <= quiet + 8'h01;
        end
    end
    assign owner_link_lost_o = (quiet == 8'hff);
endmodule

`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "icd_defines.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %s expected %0h seen %0h", nm, e, g); end end

module testbench;
    import icd_pkg::*;
    logic                    clk_i, srst_i, avs_read_i, avs_write_i, irq_o;
    logic                    avs_waitrequest_o, wait_q, overheat_sense_i, link_lost;
    logic [7:0]              avs_address_i;
    logic [31:0]             avs_writedata_i, avs_readdata_o, rd_q, q;
    logic [3:0]              avs_byteenable_i;
    logic [15:0]             diag_change_counter_o, cnt0;
    icd_sample_t [3:0]       sample_i;
    icd_report_t [3:0]       report_o, last;
    int                      err_total, n_compared;

    icd_input_channel_diagnostics u_dut (.clk_i(clk_i), .srst_i(srst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .sample_i(sample_i), .overheat_sense_i(overheat_sense_i), .report_o(report_o),
        .diag_change_counter_o(diag_change_counter_o), .irq_o(irq_o));
    icd_ctrl_model u_ctrl (.clk_i(clk_i), .srst_i(srst_i), .report_i(report_o),
        .last_o(last), .owner_link_lost_o(link_lost));

    // Clock, 40 ns period
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // Settled bus answer, captured mid-cycle for the next rising edge
    always @(negedge clk_i) begin
        wait_q = avs_waitrequest_o;
        rd_q   = avs_readdata_o;
    end

    task automatic stop_test();
        if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One Avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_write_i     <= wr;
        avs_read_i      <= !wr;
        do begin
            @(posedge clk_i);
        end while (wait_q !== 1'b0);
        q = rd_q;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        @(negedge clk_i);
    endtask

    // One front-end sample, report checked one cycle later
    task automatic smp(input int c, input logic [23:0] v, input logic wo, qb, cqb,
                       input logic [23:0] cj);
        @(posedge clk_i);
        sample_i[c] <= '{1'b1, v, wo, qb, cqb, cj};
        @(posedge clk_i);
        sample_i[c].valid <= 1'b0;
        @(negedge clk_i);
        `CHK("rep_valid", 1'b1, report_o[c].valid)
    endtask

    // Reset values, signed offset, unmapped place, per-channel units
    task automatic t_regs();
        bus(1'b0, 8'h00, 32'h0000_0000);
        `CHK("cfg0_rst", 32'h0000_0000, q)
        `CHK("cnt_rst", 16'h0000, diag_change_counter_o)
        bus(1'b1, 8'h10, 32'h0000_ffe6);
        bus(1'b0, 8'h10, 32'h0000_0000);
        `CHK("ofs0", 32'hffff_ffe6, q)
        bus(1'b0, 8'hfc, 32'h0000_0000);
        `CHK("unmapped", 32'h0000_0000, q)
        for (int u = 0; u < 5; u++) begin
            bus(1'b1, 8'((u % 4) * 4), 32'(u) << 6);
            smp(u % 4, 24'h00_03e8, 1'b0, 1'b0, 1'b0, 24'h00_0000);
            `CHK("unit", 3'(u), report_o[u % 4].unit)
        end
    endtask

    // Copper offset only with the ten-ohm copper sensor in RTD mode
    task automatic t_copper();
        bus(1'b1, 8'h00, 32'h0000_0022);
        smp(0, 24'h00_03e8, 1'b0, 1'b0, 1'b0, 24'h00_0000);
        `CHK("cu_val", 24'h00_03ce, report_o[0].value)
        @(negedge clk_i);
        `CHK("ctl_val", 24'h00_03ce, last[0].value)
        bus(1'b1, 8'h00, 32'h0000_000e);
        smp(0, 24'h00_03e8, 1'b0, 1'b0, 1'b0, 24'h00_0000);
        `CHK("pt_val", 24'h00_03e8, report_o[0].value)
    endtask

    // Wire-break table on channel 0, all alarms disabled meanwhile
    task automatic t_wire();
        logic [31:0] cf [10] = '{32'h0000_0200, 32'h0000_0200, 32'h0000_0000, 32'h0000_0201,
            32'h0000_0201, 32'h0000_0a01, 32'h0000_0202, 32'h0000_0203, 32'h0000_023f,
            32'h0000_0202};
        logic [23:0] vv [10] = '{24'h01_869f, 24'h01_86a0, 24'h00_0000, 24'h00_2710,
            24'h00_270f, 24'h00_1388, 24'h00_0064, 24'h00_0064, 24'h00_0064, 24'h00_0064};
        logic [9:0]  wo = 10'h1c0;
        logic [9:0]  ex = 10'h1e9;
        bus(1'b1, 8'h20, 32'h0000_0001);
        bus(1'b0, 8'h20, 32'h0000_0000);
        `CHK("no_alarms", 32'h0000_0001, q)
        for (int i = 0; i < 10; i++) begin
            bus(1'b1, 8'h00, cf[i]);
            smp(0, vv[i], wo[i], 1'b0, 1'b0, 24'h00_0000);
            `CHK("wb", ex[i], report_o[0].wire_break_flag)
            `CHK("fault", ex[i], report_o[0].fault)
            bus(1'b0, 8'h24, 32'h0000_0000);
            `CHK("flags_wb", ex[i], q[0])
        end
    endtask

    // Cold junction correction, its disable, quality faults on channel 0
    task automatic t_cj();
        logic [31:0] cf [3] = '{32'h0000_0003, 32'h0000_0403, 32'h0000_003f};
        logic [23:0] ev [3] = '{24'h00_0208, 24'h00_01f4, 24'h00_01f4};
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, 8'h00, cf[i]);
            smp(0, 24'h00_01f4, 1'b0, 1'b0, 1'b0, 24'h00_0014);
            `CHK("tc_val", ev[i], report_o[0].value)
        end
        bus(1'b1, 8'h00, 32'h0000_0003);
        smp(0, 24'h00_01f4, 1'b0, 1'b1, 1'b1, 24'h00_0014);
        `CHK("q_fault", 1'b1, report_o[0].fault)
        `CHK("q_wb", 1'b0, report_o[0].wire_break_flag)
        `CHK("cj_bad", 1'b1, report_o[0].cold_junction_bad_flag)
    endtask

    // Masked and unmasked interrupt, read-clear, change counter
    task automatic t_irq();
        bus(1'b0, 8'h28, 32'h0000_0000);
        bus(1'b1, 8'h2c, 32'h0000_0000);
        bus(1'b1, 8'h0c, 32'h0000_0200);
        cnt0 = diag_change_counter_o;
        smp(3, 24'h00_0000, 1'b0, 1'b0, 1'b0, 24'h00_0000);
        `CHK("irq_masked", 1'b0, irq_o)
        `CHK("cnt_inc", cnt0 + 16'h0001, diag_change_counter_o)
        bus(1'b0, 8'h30, 32'h0000_0000);
        `CHK("cnt_reg", {16'h0000, cnt0 + 16'h0001}, q)
        bus(1'b1, 8'h2c, 32'h0000_1000);
        `CHK("irq_on", 1'b1, irq_o)
        bus(1'b0, 8'h28, 32'h0000_0000);
        `CHK("stat_wb3", 1'b1, q[12])
        `CHK("irq_clr", 1'b0, irq_o)
    endtask

    // Over-temperature reaches every channel's record
    task automatic t_ovh(input logic lvl);
        @(posedge clk_i);
        overheat_sense_i <= lvl;
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        for (int c = 0; c < 4; c++) begin
            `CHK("ovht", lvl, report_o[c].overheat_flag)
        end
    endtask

    // Silence on the report stream is seen as a lost owner link
    task automatic t_link();
        `CHK("link_ok", 1'b0, link_lost)
        repeat (260) @(posedge clk_i);
        @(negedge clk_i);
        `CHK("link_lost", 1'b1, link_lost)
    endtask

    // Time-zero values, reset, scenarios
    initial begin
        err_total = 0;
        n_compared = 0;
        srst_i = 1'b1;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_address_i = 8'h00;
        avs_writedata_i = 32'h0000_0000;
        avs_byteenable_i = 4'hf;
        overheat_sense_i = 1'b0;
        sample_i = '0;
        repeat (16) @(posedge clk_i);
        srst_i <= 1'b0;
        t_regs();
        t_copper();
        t_wire();
        t_cj();
        t_irq();
        t_ovh(1'b1);
        t_ovh(1'b0);
        t_link();
        stop_test();
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        stop_test();
    end
endmodule

`default_nettype wire
